/* design/agc_rf_tx_consts.vh */
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: Included by the register bank and the gain loop timer
// Notes: Byte address is four times the register index
`ifndef AGC_RF_TX_CONSTS_VH
`define AGC_RF_TX_CONSTS_VH
// Register indexes
`define IDX_GAIN_CFG 6'h1e
`define IDX_GAIN_STATIC 6'h1f
`define IDX_TX_SHAPING 6'h20
`define IDX_TX_CLOCK 6'h21
// gain_control_config fields
`define GC_SETPOINT_HI 15
`define GC_SETPOINT_LO 14
`define GC_PERIOD_HI 13
`define GC_PERIOD_LO 4
`define GC_SOURCE_BIT 3
`define GC_LOAD_BIT 2
`define GC_MODE_BIT 1
`define GC_ENABLE_BIT 0
`define GC_SETPOINT_RST 2'h2
`define GC_PERIOD_RST 10'h200
`define GC_MODE_RST 1'h1
`define GC_ENABLE_RST 1'h1
// Set point codes
`define SP_1V15 2'h0
`define SP_1V40 2'h1
`define SP_1V50 2'h2
`define SP_RESERVED 2'h3
// gain_static_values fields
`define GS_READER_HI 19
`define GS_READER_LO 10
`define GS_CARD_HI 9
`define GS_CARD_LO 0
`define GAIN_MOST_ROBUST 10'h3ff
// transmit_shaping_control fields
`define TS_DRV_SEL_BIT 26
`define TS_AMP_HI 25
`define TS_AMP_LO 24
`define TS_PREV_RC_HI 23
`define TS_PREV_RC_LO 19
`define TS_MAX_BIT 18
`define TS_RC_HI 17
`define TS_RC_LO 13
`define TS_BYPASS_BIT 12
`define TS_SLEW_HI 11
`define TS_SLEW_LO 8
`define TS_FALL_HI 7
`define TS_FALL_LO 4
`define TS_RISE_HI 3
`define TS_RISE_LO 0
`define TS_WMASK 32'h07ffffff
// transmit_clock_control fields
`define TC_LM_EN_BIT 18
`define TC_PHASE_HI 13
`define TC_PHASE_LO 11
`define TC_PREV_CM_HI 10
`define TC_PREV_CM_LO 8
`define TC_INV2_BIT 7
`define TC_WMASK 32'h00043f80
// Carrier clock enable: 250 MHz / 13.56 MHz, rounded down to whole cycles
`define CLK_KHZ 250000
`define CARRIER_KHZ 13560
`define CARRIER_DIV (`CLK_KHZ / `CARRIER_KHZ)
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2
`endif

/* design/gain_period_timer.v */
// Purpose: Carrier-rate tick and gain loop update pulse
// Assumes: Enabled only in automatic gain operation
// Notes: One update per (period+1) carrier cycles
`default_nettype none
`include "agc_rf_tx_consts.vh"
module gain_period_timer (
  input wire aclk,
  input wire aresetn,
  input wire run,
  input wire [9:0] period,
  output reg update_ff
);
  reg [4:0] div_ff;
  reg [9:0] cnt_ff;
  wire carrier_tick;

  // Carrier clock enable divider, compared at full integer width
  assign carrier_tick = ({27'h0000000, div_ff} == (`CARRIER_DIV - 1));
  always @(posedge aclk)
  begin
    if (!aresetn || carrier_tick)
      div_ff <= 5'h00;
    else
      div_ff <= div_ff + 5'h01;
  end

  // Period counter, restarts when the loop is off
  always @(posedge aclk)
  begin
    if (!aresetn || !run)
    begin
      cnt_ff <= 10'h000;
      update_ff <= 1'b0;
    end
    else
    begin
      update_ff <= 1'b0;
      if (carrier_tick)
      begin
        if (cnt_ff >= period)
        begin
          cnt_ff <= 10'h000;
          update_ff <= 1'b1;
        end
        else
          cnt_ff <= cnt_ff + 10'h001;
      end
    end
  end
endmodule // gain_period_timer
`default_nettype wire

/* design/agc_rf_tx_control.v */
// Purpose: Gain control and transmitter configuration register bank
// Assumes: AXI4-Lite slave on aclk, synchronous active-low reset
// Notes: Loop step input comes from the analog gain detector
// Operation
// RULE1: Set point code picks 1.15/1.40/1.50 V
// RULE2: Loop updates every period plus one carrier
// RULE3: Software keeps period value at least four
// RULE4: Source bit picks card or reader value
// RULE5: Load strobe copies value, clears itself
// RULE6: Fixed mode follows static or freezes
// RULE7: Mode bit change loads nothing
// RULE8: Enable bit: fixed at 0, loop at 1
// RULE9: Static register: reader high, card low
// RULE10: Code 3FFh is the most robust setting
// RULE11: Driver select: both at 0, single at 1
// RULE12: Max carrier bit overrides amplitude field
// RULE13: Residual code 0 full, 1F none
// RULE14: Prevention pattern uses separate residual field
// RULE15: Bypass disables shaping and rising constant
// RULE16: Slew field serves both edges
// RULE17: Edge constants only in single pump mode
// RULE18: Load-mod enable selects active card modulation
// RULE19: Phase field in 45 degree steps
// RULE20: Prevention uses its own clock mode
// RULE21: Reader mode second driver inverts carrier
// RULE22: Reserved bits read zero, writes ignored
//
// The implementer's own choice: the AXI4-Lite slave port.
`default_nettype none
`include "agc_rf_tx_consts.vh"
module agc_rf_tx_control (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire reader_mode,
  input wire single_pump_mode,
  input wire prevention_active,
  input wire [1:0] gain_loop_step,
  output reg [1:0] gain_setpoint_ff,
  output reg [9:0] rx_divider_ff,
  output reg gain_update_ff,
  output reg both_drivers_ff,
  output reg [1:0] card_amplitude_ff,
  output reg card_carrier_max_ff,
  output reg [4:0] residual_carrier_ff,
  output reg sc_shaping_on_ff,
  output reg [3:0] shunt_slew_ff,
  output reg [3:0] fall_tau_ff,
  output reg [3:0] rise_tau_ff,
  output reg active_load_mod_ff,
  output reg [2:0] phase_offset_ff,
  output reg [2:0] prevention_clock_mode_ff,
  output reg use_prevention_clock_ff,
  output reg second_driver_invert_ff
);
  // Stored register fields
  reg [1:0] setpoint_ff;
  reg [9:0] period_ff;
  reg source_sel_ff;
  reg mode_sel_ff;
  reg loop_en_ff;
  reg [9:0] reader_gain_ff;
  reg [9:0] card_gain_ff;
  reg [31:0] shaping_ff;
  reg [31:0] clkctl_ff;
  // Write channel capture
  reg [7:0] awaddr_ff;
  reg aw_held_ff;
  reg [31:0] wdata_ff;
  reg [3:0] wstrb_ff;
  reg w_held_ff;
  wire [31:0] bmask;
  wire do_write;
  wire [5:0] widx;
  wire [5:0] ridx;
  wire [9:0] static_sel;
  wire loop_tick;
  reg [31:0] nxt_rdata;
  reg nxt_rok;
  reg [31:0] cfg_rd;
  wire [31:0] cfg_wr;
  wire [31:0] stat_wr;
  wire load_now;
  reg [3:0] step_pipe_ff;

  genvar g;
  // Byte-enable mask, one lane per strobe
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_lane
      assign bmask[8*g+7:8*g] = {8{wstrb_ff[g]}};
    end
  endgenerate

  assign do_write = aw_held_ff && w_held_ff && !s_axi_bvalid;
  assign widx = awaddr_ff[7:2];
  assign ridx = s_axi_araddr[7:2];

  // Current config word and its byte-merged write image
  always @*
  begin
    cfg_rd = 32'h00000000;
    cfg_rd[`GC_SETPOINT_HI:`GC_SETPOINT_LO] = setpoint_ff;
    cfg_rd[`GC_PERIOD_HI:`GC_PERIOD_LO] = period_ff;
    cfg_rd[`GC_SOURCE_BIT] = source_sel_ff;
    cfg_rd[`GC_MODE_BIT] = mode_sel_ff;
    cfg_rd[`GC_ENABLE_BIT] = loop_en_ff;
  end
  assign cfg_wr = (wdata_ff & bmask) | (cfg_rd & ~bmask);
  assign stat_wr = (wdata_ff & bmask) |
    ({12'h000, reader_gain_ff, card_gain_ff} & ~bmask);
  // RULE5: load strobe pulse
  assign load_now = do_write && (widx == `IDX_GAIN_CFG) &&
    wstrb_ff[0] && wdata_ff[`GC_LOAD_BIT];

  // AXI write address and data capture, either order
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AXI_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_held_ff && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_held_ff && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (widx >= `IDX_GAIN_CFG && widx <= `IDX_TX_CLOCK)
          s_axi_bresp <= `AXI_OKAY;
        else
          s_axi_bresp <= `AXI_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Register writes
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      // RULE1: set point reset
      setpoint_ff <= `GC_SETPOINT_RST;
      period_ff <= `GC_PERIOD_RST;
      source_sel_ff <= 1'b0;
      mode_sel_ff <= `GC_MODE_RST;
      // RULE8: loop on at reset
      loop_en_ff <= `GC_ENABLE_RST;
      // RULE9: static values reset to zero
      reader_gain_ff <= 10'h000;
      card_gain_ff <= 10'h000;
      shaping_ff <= 32'h00000000;
      clkctl_ff <= 32'h00000000;
    end
    else if (do_write)
    begin
      case (widx)
        `IDX_GAIN_CFG:
        begin
          // RULE1: reserved code kept as written
          setpoint_ff <= cfg_wr[`GC_SETPOINT_HI:`GC_SETPOINT_LO];
          // RULE3: minimum is up to software
          period_ff <= cfg_wr[`GC_PERIOD_HI:`GC_PERIOD_LO];
          source_sel_ff <= cfg_wr[`GC_SOURCE_BIT];
          mode_sel_ff <= cfg_wr[`GC_MODE_BIT];
          loop_en_ff <= cfg_wr[`GC_ENABLE_BIT];
        end
        `IDX_GAIN_STATIC:
        begin
          // RULE9: field split
          reader_gain_ff <= stat_wr[`GS_READER_HI:`GS_READER_LO];
          card_gain_ff <= stat_wr[`GS_CARD_HI:`GS_CARD_LO];
        end
        // RULE22: reserved bits masked off
        `IDX_TX_SHAPING:
          shaping_ff <= ((wdata_ff & bmask) | (shaping_ff & ~bmask)) &
            `TS_WMASK;
        `IDX_TX_CLOCK:
          clkctl_ff <= ((wdata_ff & bmask) | (clkctl_ff & ~bmask)) &
            `TC_WMASK;
        default:
          shaping_ff <= shaping_ff;
      endcase
    end
  end

  // Read data mux; load strobe always reads zero
  always @*
  begin
    nxt_rdata = 32'h00000000;
    nxt_rok = 1'b1;
    case (ridx)
      `IDX_GAIN_CFG: nxt_rdata = cfg_rd;
      `IDX_GAIN_STATIC: nxt_rdata = {12'h000, reader_gain_ff, card_gain_ff};
      `IDX_TX_SHAPING: nxt_rdata = shaping_ff;
      `IDX_TX_CLOCK: nxt_rdata = clkctl_ff;
      default: nxt_rok = 1'b0;
    endcase
  end

  // AXI read channel
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `AXI_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= nxt_rdata;
        s_axi_rresp <= nxt_rok ? `AXI_OKAY : `AXI_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // RULE4: static source select
  assign static_sel = source_sel_ff ? reader_gain_ff : card_gain_ff;

  // RULE2: period timer
  gain_period_timer u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(loop_en_ff),
    .period(period_ff),
    .update_ff(loop_tick)
  );

  // Detector step is asynchronous: two flops before any use
  always @(posedge aclk)
    step_pipe_ff <= aresetn ? {step_pipe_ff[1:0], gain_loop_step} : 4'h0;

  // Receive divider: load, fixed follow, freeze, or loop steps
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_divider_ff <= 10'h000;
      gain_update_ff <= 1'b0;
    end
    else
    begin
      gain_update_ff <= loop_tick;
      // RULE5: load strobe copies selected value
      if (load_now)
        rx_divider_ff <= static_sel;
      // RULE6: fixed mode with mode bit 0 follows
      else if (!loop_en_ff && !mode_sel_ff)
        rx_divider_ff <= static_sel;
      // RULE8: loop operation steps on update
      else if (loop_en_ff && loop_tick)
      begin
        // RULE10: clamp at most robust code
        if (step_pipe_ff[3:2] == 2'h1 && rx_divider_ff != `GAIN_MOST_ROBUST)
          rx_divider_ff <= rx_divider_ff + 10'h001;
        else if (step_pipe_ff[3:2] == 2'h2 && rx_divider_ff != 10'h000)
          rx_divider_ff <= rx_divider_ff - 10'h001;
      end
      // RULE7: mode bit alone loads nothing
    end
  end

  // Transmitter steering outputs
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      gain_setpoint_ff <= `GC_SETPOINT_RST;
      both_drivers_ff <= 1'b1;
      card_amplitude_ff <= 2'h0;
      card_carrier_max_ff <= 1'b0;
      residual_carrier_ff <= 5'h00;
      sc_shaping_on_ff <= 1'b1;
      shunt_slew_ff <= 4'h0;
      fall_tau_ff <= 4'h0;
      rise_tau_ff <= 4'h0;
      active_load_mod_ff <= 1'b0;
      phase_offset_ff <= 3'h0;
      prevention_clock_mode_ff <= 3'h0;
      use_prevention_clock_ff <= 1'b0;
      second_driver_invert_ff <= 1'b0;
    end
    else
    begin
      gain_setpoint_ff <= setpoint_ff;
      // RULE11: driver select
      both_drivers_ff <= !shaping_ff[`TS_DRV_SEL_BIT];
      // RULE12: max carrier overrides amplitude
      card_carrier_max_ff <= shaping_ff[`TS_MAX_BIT];
      card_amplitude_ff <= shaping_ff[`TS_MAX_BIT] ? 2'h0 :
        shaping_ff[`TS_AMP_HI:`TS_AMP_LO];
      // RULE14: prevention residual carrier
      // RULE13: code passed straight to driver
      residual_carrier_ff <= prevention_active ?
        shaping_ff[`TS_PREV_RC_HI:`TS_PREV_RC_LO] :
        shaping_ff[`TS_RC_HI:`TS_RC_LO];
      // RULE15: bypass disables shaping
      sc_shaping_on_ff <= !shaping_ff[`TS_BYPASS_BIT];
      // RULE16: common slew for both edges
      shunt_slew_ff <= shaping_ff[`TS_SLEW_HI:`TS_SLEW_LO];
      // RULE17: edge constants only in single pump
      fall_tau_ff <= single_pump_mode ?
        shaping_ff[`TS_FALL_HI:`TS_FALL_LO] : 4'h0;
      rise_tau_ff <= (single_pump_mode && !shaping_ff[`TS_BYPASS_BIT]) ?
        shaping_ff[`TS_RISE_HI:`TS_RISE_LO] : 4'h0;
      // RULE18: active load modulation in card mode
      active_load_mod_ff <= clkctl_ff[`TC_LM_EN_BIT] && !reader_mode;
      // RULE19: phase steps of 45 degrees
      phase_offset_ff <= clkctl_ff[`TC_PHASE_HI:`TC_PHASE_LO];
      // RULE20: prevention clock mode
      prevention_clock_mode_ff <= clkctl_ff[`TC_PREV_CM_HI:`TC_PREV_CM_LO];
      use_prevention_clock_ff <= prevention_active;
      // RULE21: reader mode invert only
      second_driver_invert_ff <= reader_mode && clkctl_ff[`TC_INV2_BIT];
    end
  end
endmodule // agc_rf_tx_control
`default_nettype wire

/* testbench/agc_rf_tx_control_asserts.sv */
// Purpose: Port checks of the gain and transmit register bank
// Assumes: Outputs follow their causes by one clock
// Notes: Attached by the bind below
`default_nettype none
module agc_rf_tx_control_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic reader_mode,
  input wire logic single_pump_mode,
  input wire logic prevention_active,
  input wire logic [1:0] gain_setpoint_ff,
  input wire logic gain_update_ff,
  input wire logic [1:0] card_amplitude_ff,
  input wire logic card_carrier_max_ff,
  input wire logic sc_shaping_on_ff,
  input wire logic [3:0] fall_tau_ff,
  input wire logic [3:0] rise_tau_ff,
  input wire logic active_load_mod_ff,
  input wire logic use_prevention_clock_ff,
  input wire logic second_driver_invert_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  // One clock domain, checks paused in reset
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Output relations
  property p_sp;
    $rose(aresetn) |-> gain_setpoint_ff == 2'h2;
  endproperty
  a_sp: assert property (p_sp) else $error("set point reset");
  property p_upd;
    gain_update_ff |=> !gain_update_ff [*8];
  endproperty
  a_upd: assert property (p_upd) else $error("update too soon");
  property p_amp;
    card_carrier_max_ff |-> card_amplitude_ff == 2'h0;
  endproperty
  a_amp: assert property (p_amp) else $error("amplitude kept");
  property p_rise;
    rise_tau_ff != 4'h0 |-> sc_shaping_on_ff;
  endproperty
  a_rise: assert property (p_rise) else $error("rise in bypass");
  property p_tau;
    (fall_tau_ff | rise_tau_ff) != 4'h0 |-> $past(single_pump_mode);
  endproperty
  a_tau: assert property (p_tau) else $error("tau not single");
  property p_alm;
    active_load_mod_ff |-> !$past(reader_mode);
  endproperty
  a_alm: assert property (p_alm) else $error("alm in reader");
  property p_pclk;
    $past(aresetn) |-> use_prevention_clock_ff == $past(prevention_active);
  endproperty
  a_pclk: assert property (p_pclk) else $error("prev clock");
  property p_inv;
    second_driver_invert_ff |-> $past(reader_mode);
  endproperty
  a_inv: assert property (p_inv) else $error("invert in card");
  // Main scenarios reached
  c_upd: cover property (gain_update_ff);
  c_alm: cover property (active_load_mod_ff);
  c_inv: cover property (second_driver_invert_ff && use_prevention_clock_ff);
endmodule // agc_rf_tx_control_asserts
bind agc_rf_tx_control agc_rf_tx_control_asserts chk (
  .aclk, .aresetn, .reader_mode, .single_pump_mode, .prevention_active,
  .gain_setpoint_ff, .gain_update_ff, .card_amplitude_ff,
  .card_carrier_max_ff, .sc_shaping_on_ff, .fall_tau_ff, .rise_tau_ff,
  .active_load_mod_ff, .use_prevention_clock_ff, .second_driver_invert_ff
);
`default_nettype wire

/* testbench/agc_rf_tx_control_tb.sv */
// Purpose: Self-checking bench of the gain and transmit register bank
// Assumes: AXI4-Lite master waits for every answer, 4 ns clock
// Notes: Table rows cover register access, hand tests the rest
`default_nettype none
module agc_rf_tx_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb, shunt_slew_ff, fall_tau_ff, rise_tau_ff;
  logic [1:0] s_axi_bresp, s_axi_rresp, gain_loop_step, rs;
  logic reader_mode, single_pump_mode, prevention_active;
  logic [1:0] gain_setpoint_ff, card_amplitude_ff;
  logic [9:0] rx_divider_ff;
  logic gain_update_ff, both_drivers_ff, card_carrier_max_ff;
  logic sc_shaping_on_ff, active_load_mod_ff, use_prevention_clock_ff;
  logic second_driver_invert_ff;
  logic [4:0] residual_carrier_ff;
  logic [2:0] phase_offset_ff, prevention_clock_mode_ff;
  int fails, checks, i, n, k;
  // Rows: address, word written, response, word read back
  logic [7:0] ra [6] = '{8'h78, 8'h7c, 8'h80, 8'h84, 8'h70, 8'h78};
  logic [31:0] rw [6] = '{6{32'hffffffff}};
  logic [1:0] rp [6] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h0};
  logic [31:0] rx [6] = '{32'h0000fffb, 32'h000fffff, 32'h07ffffff,
    32'h00043f80, 32'h0, 32'h0000fffb};

  agc_rf_tx_control dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .reader_mode, .single_pump_mode,
    .prevention_active, .gain_loop_step, .gain_setpoint_ff, .rx_divider_ff,
    .gain_update_ff, .both_drivers_ff, .card_amplitude_ff,
    .card_carrier_max_ff, .residual_carrier_ff, .sc_shaping_on_ff,
    .shunt_slew_ff, .fall_tau_ff, .rise_tau_ff, .active_load_mod_ff,
    .phase_offset_ff, .prevention_clock_mode_ff, .use_prevention_clock_ff,
    .second_driver_invert_ff
  );

  // Free-running clock
  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic final_report;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic tmo;
    chk("timeout", 32'h1, 32'h0);
    final_report;
  endtask

  // Bus write: address and data together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    int c;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (c = 0; c < 40; c++)
    begin
      @(negedge aclk);
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      hb = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge aclk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
      if (hb) break;
    end
    s_axi_bready <= 1'b0;
    if (c == 40) tmo;
  endtask

  // Bus read: data and response taken with rvalid
  task automatic rdr(input logic [7:0] a);
    logic ha, hb;
    int c;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (c = 0; c < 40; c++)
    begin
      @(negedge aclk);
      ha = s_axi_arvalid && s_axi_arready;
      hb = s_axi_rvalid;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
      if (ha) s_axi_arvalid <= 1'b0;
      if (hb) break;
    end
    s_axi_rready <= 1'b0;
    if (c == 40) tmo;
  endtask

  // Set mode inputs, then let registered outputs settle
  task automatic inp(input logic rm, sp, pa);
    @(posedge aclk);
    reader_mode <= rm;
    single_pump_mode <= sp;
    prevention_active <= pa;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
  endtask

  // Main sequence
  initial
  begin
    fails = 0;
    checks = 0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    s_axi_awaddr = 8'h0;
    s_axi_araddr = 8'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    {reader_mode, single_pump_mode, prevention_active} = 3'h0;
    gain_loop_step = 2'h1;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(8'h78);
    chk("cfg reset", rd, 32'h0000a003);
    chk("set point", gain_setpoint_ff, 32'h2);
    chk("both drivers", both_drivers_ff, 32'h1);
    rdr(8'h7c);
    chk("static reset", rd, 32'h0);
    for (i = 0; i < 6; i++)
    begin
      wr(ra[i], rw[i]);
      chk("write resp", rs, rp[i]);
      rdr(ra[i]);
      chk("read resp", rs, rp[i]);
      chk("read data", rd, rx[i]);
    end
    inp(1'b0, 1'b1, 1'b0);
    chk("max amp", {card_carrier_max_ff, card_amplitude_ff}, 32'h4);
    chk("bypass", {sc_shaping_on_ff, rise_tau_ff}, 32'h0);
    chk("one driver", both_drivers_ff, 32'h0);
    chk("residual none", residual_carrier_ff, 32'h1f);
    wr(8'h80, 32'h032b4369);
    inp(1'b0, 1'b1, 1'b0);
    chk("amplitude", card_amplitude_ff, 32'h3);
    chk("residual", residual_carrier_ff, 32'h1a);
    chk("slew", shunt_slew_ff, 32'h3);
    chk("taus", {fall_tau_ff, rise_tau_ff}, 32'h69);
    inp(1'b0, 1'b0, 1'b1);
    chk("prev residual", residual_carrier_ff, 32'h5);
    chk("tau off", {fall_tau_ff, rise_tau_ff}, 32'h0);
    wr(8'h84, 32'h00042e80);
    for (k = 0; k < 2; k++)
    begin
      inp(k[0], 1'b0, k[0]);
      chk("alm", active_load_mod_ff, k ^ 1);
      chk("invert", second_driver_invert_ff, k);
      chk("prev clock", use_prevention_clock_ff, k);
    end
    chk("phase", phase_offset_ff, 32'h5);
    chk("prev mode", prevention_clock_mode_ff, 32'h6);
    wr(8'h7c, 32'h000ffd55);
    for (k = 0; k < 3; k++)
    begin
      wr(8'h78, 32'h40 | (k << 14));
      inp(1'b0, 1'b0, 1'b0);
      chk("set point", gain_setpoint_ff, k);
    end
    chk("card value", rx_divider_ff, 32'h155);
    wr(8'h78, 32'h8048);
    inp(1'b0, 1'b0, 1'b0);
    chk("reader value", rx_divider_ff, 32'h3ff);
    wr(8'h78, 32'h8042);
    inp(1'b0, 1'b0, 1'b0);
    chk("frozen", rx_divider_ff, 32'h3ff);
    wr(8'h78, 32'h8046);
    inp(1'b0, 1'b0, 1'b0);
    chk("loaded", rx_divider_ff, 32'h155);
    rdr(8'h78);
    chk("load clears", rd, 32'h8042);
    // Loop on, period 4: updates every 5 carrier ticks of 18 clocks
    wr(8'h78, 32'h8041);
    @(negedge aclk);
    for (i = 0; i < 400 && gain_update_ff !== 1'b1; i++) @(negedge aclk);
    if (i == 400) tmo;
    @(negedge aclk);
    for (n = 1; n < 400 && gain_update_ff !== 1'b1; n++) @(negedge aclk);
    if (n == 400) tmo;
    chk("update gap", n, 32'd90);
    repeat (3) @(negedge aclk);
    chk("loop steps", rx_divider_ff, 32'h157);
    // Mid-run reset restores defaults
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(8'h78);
    chk("cfg again", rd, 32'h0000a003);
    final_report;
  end
endmodule // agc_rf_tx_control_tb
`default_nettype wire
